// [src/mbr_pkg.sv]
// Shared constants and types of the read-query responder.
// Assumes the serial framer hands over decoded bytes in both framing modes.
package mbr_pkg;

  // Function codes and exception answers
  localparam logic [7:0] FUNC_DISC = 8'h02;
  localparam logic [7:0] FUNC_HOLD = 8'h03;
  localparam logic [7:0] FUNC_INPUT = 8'h04;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // Slave address range
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;

  // Query lengths including the check field
  localparam logic [3:0] QUERY_LEN_BIN = 4'h8;
  localparam logic [3:0] QUERY_LEN_TEXT = 4'h7;

  // Discrete inputs: bit index is protocol address, input number minus one
  localparam logic [16:0] DISC_COUNT = 17'h00015;
  localparam int DISC_RELAY_POS = 18;
  localparam int DISC_LOOPA_POS = 19;
  localparam logic [15:0] DISC_QTY_MAX = 16'h07D0;
  localparam logic [15:0] REG_QTY_MAX = 16'h007D;

  // Register map
  localparam logic [15:0] TEMP_ADDR = 16'h0008;
  localparam logic [15:0] RELAY_MAP_ADDR = 16'h0073;
  localparam int MAP_BIAS_POS = 0;
  localparam int MAP_BAND1_POS = 1;
  localparam int MAP_BAND2_POS = 2;
  localparam int MAP_TEMP_POS = 3;
  localparam int MAP_PEAK_POS = 4;
  localparam int MAP_GAP_POS = 5;
  localparam int MAP_WIDTH = 6;

  // Error check
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] qty;
  } mbr_query_t;

  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_SEND} mbr_state_t;

endpackage

// [src/mbr_check.sv]
// Running error-check accumulator: binary-mode CRC and text-mode byte sum.
// Assumes clear and step are never asked for in the same cycle by intent.
`timescale 1ns/10ps
`default_nettype none
module mbr_check
  import mbr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Byte feed
  input wire logic clear,
  input wire logic step,
  input wire logic [7:0] data,
  // Results
  output logic [15:0] crc,
  output logic [7:0] sum
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wire logic [15:0] next_crc = crc_byte(crc, data);
  wire logic [7:0] next_sum = 8'(sum + data);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc <= CRC_INIT;
      sum <= 8'h00;
    end else if (clear) begin
      crc <= CRC_INIT;
      sum <= 8'h00;
    end else if (step) begin
      crc <= next_crc;
      sum <= next_sum;
    end
  end

endmodule
`default_nettype wire

// [src/mbr_responder.sv]
// Slave-side answerer for discrete input, input register and holding
// register read queries. Assumes a framer that delivers query bytes,
// marks frame end, and drains the response bytes with a ready handshake.
// Function
// RULE_01 - Query fields in order; response echoes header
// RULE_02 - Input n sits at address n-1
// RULE_03 - Twenty-one discrete inputs are exposed
// RULE_04 - Input 19 reports relay output state
// RULE_05 - Input 20 is loop A fault
// RULE_06 - One data bit per requested input
// RULE_07 - First input in LSb, filling upward
// RULE_08 - Byte count is whole bytes needed
// RULE_09 - Unused high bits of last byte zero
// RULE_10 - Single input: count one, state in LSb
// RULE_11 - Temperature float at input registers 8,9
// RULE_12 - Master aligns reads; device returns words unchecked
// RULE_13 - Two-register read: count four, big-endian
// RULE_14 - Relay map holding register at 115
// RULE_15 - Holding register: high byte then low
// RULE_16 - Relay map low six bits route alarms
// RULE_17 - Only functions 02,03,04; else exception
// RULE_18 - Multi-register values are big-endian
// RULE_19 - Slave address 1 to 247, default 1
// RULE_20 - Ignore wrong address or bad check
// RULE_21 - Check is CRC binary, LRC text
`timescale 1ns/10ps
`default_nettype none
module mbr_responder
  import mbr_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Configuration
  input wire logic [7:0] SLAVE_ADDR,
  input wire logic TEXT_MODE,
  // Query bytes from the framer
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  // Response bytes to the framer
  input wire logic TX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  // Monitored state
  input wire logic [18:0] ALARM_STATUS,
  input wire logic RELAY_STATE,
  input wire logic LOOP_A_FAULT,
  input wire logic [31:0] TEMPERATURE,
  input wire logic [MAP_WIDTH-1:0] RELAY_MAP
);

  mbr_state_t state;
  mbr_query_t rxq;
  mbr_query_t qr;
  logic [3:0] rx_cnt;
  logic [7:0] idx;
  logic [7:0] exc_code;
  logic text_q;
  logic [20:0] disc_snap;
  logic [31:0] temp_snap;
  logic [15:0] map_snap;
  logic [15:0] rx_crc;
  logic [7:0] rx_sum;
  logic [15:0] tx_crc;
  logic [7:0] tx_sum;

  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  // Word at a register address; unmapped addresses read zero
  function automatic logic [15:0] reg_word(input logic [7:0] f, input logic [15:0] a,
                                           input logic [31:0] t, input logic [15:0] m);
    logic [15:0] w;
    w = 16'h0000;
    if (f == FUNC_INPUT && a == TEMP_ADDR) begin
      w = t[31:16]; // see RULE_11 see RULE_18
    end else if (f == FUNC_INPUT && a == 16'(TEMP_ADDR + 16'h0001)) begin
      w = t[15:0];
    end else if (f == FUNC_HOLD && a == RELAY_MAP_ADDR) begin
      w = m; // see RULE_14
    end
    return w;
  endfunction

  // Exception code for a query, zero when it is served
  function automatic logic [7:0] exc_of(input mbr_query_t q);
    logic [7:0] e;
    e = 8'h00;
    if (q.func == FUNC_DISC) begin
      if (q.qty == 16'h0000 || q.qty > DISC_QTY_MAX) begin
        e = EXC_VALUE;
      end else if (17'(q.start) + 17'(q.qty) > DISC_COUNT) begin
        e = EXC_ADDR; // see RULE_03
      end
    end else if (q.func == FUNC_HOLD || q.func == FUNC_INPUT) begin
      // Alignment of multi-word values is the master's job; see RULE_12
      if (q.qty == 16'h0000 || q.qty > REG_QTY_MAX) begin
        e = EXC_VALUE;
      end
    end else begin
      e = EXC_FUNC; // see RULE_17
    end
    return e;
  endfunction

  // Out-of-range configuration falls back to the default address
  wire logic addr_ok = SLAVE_ADDR >= ADDR_MIN && SLAVE_ADDR <= ADDR_MAX;
  wire logic [7:0] own_addr = addr_ok ? SLAVE_ADDR : ADDR_DEFAULT; // see RULE_19

  // Receive side
  wire logic rx_take = RX_VALID && state == S_IDLE;
  wire logic [3:0] query_len = TEXT_MODE ? QUERY_LEN_TEXT : QUERY_LEN_BIN;
  wire logic rx_check_ok = TEXT_MODE ? (rx_sum == 8'h00) : (rx_crc == 16'h0000);
  wire logic accept = RX_END && state == S_IDLE && rx_cnt == query_len
                      && rxq.addr == own_addr && rx_check_ok; // see RULE_20 see RULE_19

  mbr_query_t next_rxq;
  always_comb begin
    next_rxq = rxq;
    unique case (rx_cnt) // see RULE_01
      4'h0: next_rxq.addr = RX_DATA;
      4'h1: next_rxq.func = RX_DATA;
      4'h2: next_rxq.start[15:8] = RX_DATA;
      4'h3: next_rxq.start[7:0] = RX_DATA;
      4'h4: next_rxq.qty[15:8] = RX_DATA;
      4'h5: next_rxq.qty[7:0] = RX_DATA;
      default: next_rxq = rxq;
    endcase
  end

  mbr_check u_rx_check (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .clear(RX_END),
    .step(rx_take),
    .data(RX_DATA),
    .crc(rx_crc),
    .sum(rx_sum)
  );

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rx_cnt <= 4'h0;
      rxq <= '0;
    end else if (RX_END) begin
      rx_cnt <= 4'h0;
    end else if (rx_take) begin
      rxq <= next_rxq;
      rx_cnt <= (rx_cnt == 4'hF) ? rx_cnt : 4'(rx_cnt + 4'h1);
    end
  end

  // Snapshot of the monitored state, so one answer is self-consistent
  wire logic [20:0] disc_now;
  assign disc_now[17:0] = ALARM_STATUS[17:0]; // see RULE_02
  assign disc_now[DISC_RELAY_POS] = RELAY_STATE; // see RULE_04
  assign disc_now[DISC_LOOPA_POS] = LOOP_A_FAULT; // see RULE_05
  assign disc_now[20] = ALARM_STATUS[18];
  wire logic [15:0] map_now = {{(16 - MAP_WIDTH){1'b0}}, RELAY_MAP}; // see RULE_16

  // Response byte selection
  wire logic exc = exc_code != 8'h00;
  wire logic [7:0] byte_cnt = (qr.func == FUNC_DISC)
                              ? 8'((17'(qr.qty) + 17'h00007) >> 3) // see RULE_08 see RULE_10
                              : 8'(qr.qty << 1); // see RULE_13 see RULE_15
  wire logic [7:0] chk_len = text_q ? 8'h01 : 8'h02;
  wire logic [7:0] data_end = exc ? 8'h02 : 8'(8'h02 + byte_cnt);
  wire logic [7:0] last_idx = 8'(data_end + chk_len);
  wire logic [7:0] k = 8'(idx - 8'h03);
  wire logic [16:0] bit_pos = 17'(qr.start) + {6'h00, k, 3'b000}; // see RULE_07
  wire logic [16:0] remain = 17'(qr.qty) - {6'h00, k, 3'b000};
  wire logic [7:0] disc_mask = (remain >= 17'h00008) ? 8'hFF
                               : 8'(8'hFF >> (4'h8 - remain[3:0])); // see RULE_09
  wire logic [31:0] disc_shift = {11'h000, disc_snap} >> bit_pos;
  wire logic [7:0] disc_byte = disc_shift[7:0] & disc_mask; // see RULE_06
  wire logic [15:0] word = reg_word(qr.func, 16'(qr.start + {9'h000, k[7:1]}),
                                    temp_snap, map_snap);
  wire logic [7:0] reg_byte = k[0] ? word[7:0] : word[15:8]; // see RULE_13 see RULE_18
  wire logic [7:0] lrc = 8'(~tx_sum + 8'h01);
  wire logic is_data = idx >= 8'h03 && idx <= data_end;
  wire logic is_chk1 = idx == 8'(data_end + 8'h01);

  logic [7:0] byte_sel;
  always_comb begin
    if (idx == 8'h00) begin
      byte_sel = qr.addr; // see RULE_01
    end else if (idx == 8'h01) begin
      byte_sel = exc ? (qr.func | EXC_FLAG) : qr.func; // see RULE_17
    end else if (idx == 8'h02) begin
      byte_sel = exc ? exc_code : byte_cnt;
    end else if (is_data) begin
      byte_sel = (qr.func == FUNC_DISC) ? disc_byte : reg_byte;
    end else if (is_chk1) begin
      byte_sel = text_q ? lrc : tx_crc[7:0]; // see RULE_21
    end else begin
      byte_sel = tx_crc[15:8];
    end
  end

  wire logic tx_fire = state == S_SEND && TX_READY;

  // Check covers every byte before the check field itself
  mbr_check u_tx_check (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .clear(accept),
    .step(tx_fire && idx <= data_end),
    .data(TX_DATA),
    .crc(tx_crc),
    .sum(tx_sum)
  ); // see RULE_21

  // One idle cycle between bytes lets the running check settle first
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state <= S_IDLE;
      qr <= '0;
      exc_code <= 8'h00;
      text_q <= 1'b0;
      disc_snap <= '0;
      temp_snap <= 32'h0000_0000;
      map_snap <= 16'h0000;
      idx <= 8'h00;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (accept) begin
            qr <= rxq;
            exc_code <= exc_of(rxq);
            text_q <= TEXT_MODE;
            disc_snap <= disc_now;
            temp_snap <= TEMPERATURE;
            map_snap <= map_now;
            idx <= 8'h00;
            state <= S_LOAD;
          end
        end
        S_LOAD: state <= S_SEND;
        S_SEND: begin
          if (TX_READY) begin
            idx <= 8'(idx + 8'h01);
            state <= (idx == last_idx) ? S_IDLE : S_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      TX_LAST <= 1'b0;
    end else if (state == S_LOAD) begin
      TX_VALID <= 1'b1;
      TX_DATA <= byte_sel;
      TX_LAST <= idx == last_idx;
    end else if (tx_fire) begin
      TX_VALID <= 1'b0;
      TX_LAST <= 1'b0;
    end
  end

  hdr_echo_a: assert property ( // see RULE_01
    (TX_VALID && idx == 8'h00) |-> TX_DATA == qr.addr && qr.addr == own_addr)
    else $error("first response byte is not the slave address");

  disc_count_a: assert property ( // see RULE_08
    (TX_VALID && idx == 8'h02 && !exc && qr.func == FUNC_DISC)
    |-> TX_DATA == 8'((17'(qr.qty) + 17'h00007) >> 3))
    else $error("discrete byte count wrong");

  single_disc_a: assert property ( // see RULE_10
    (tx_fire && idx == 8'h02 && !exc && qr.func == FUNC_DISC && qr.qty == 16'h0001)
    |-> TX_DATA == 8'h01 ##2 (TX_VALID && TX_DATA == {7'h00, disc_snap[qr.start[4:0]]}))
    else $error("single input answer wrong");

  pad_zero_a: assert property ( // see RULE_09
    (TX_VALID && !exc && qr.func == FUNC_DISC && idx == data_end && qr.qty[2:0] != 3'h0)
    |-> (TX_DATA >> qr.qty[2:0]) == 8'h00)
    else $error("unused discrete bits not zero");

  reg_count_a: assert property ( // see RULE_13
    (TX_VALID && idx == 8'h02 && !exc && qr.func != FUNC_DISC)
    |-> TX_DATA == 8'(qr.qty << 1))
    else $error("register byte count wrong");

  // Keyed on the byte index, so a stalling framer cannot shift the check
  temp_order_a: assert property ( // see RULE_11
    (TX_VALID && !exc && qr.func == FUNC_INPUT && qr.start == TEMP_ADDR
     && (idx == 8'h03 || idx == 8'h04))
    |-> TX_DATA == ((idx == 8'h03) ? temp_snap[31:24] : temp_snap[23:16]))
    else $error("temperature bytes out of order");

  relay_map_a: assert property ( // see RULE_16
    (TX_VALID && !exc && qr.func == FUNC_HOLD && qr.start == RELAY_MAP_ADDR
     && (idx == 8'h03 || idx == 8'h04))
    |-> TX_DATA == ((idx == 8'h03) ? 8'h00 : map_snap[7:0]) && map_snap[15:MAP_WIDTH] == '0)
    else $error("relay map bytes wrong");

  bad_func_a: assert property ( // see RULE_17
    (TX_VALID && idx == 8'h01 && qr.func != FUNC_DISC && qr.func != FUNC_HOLD
     && qr.func != FUNC_INPUT) |-> TX_DATA == (qr.func | EXC_FLAG) && exc_code == EXC_FUNC)
    else $error("unsupported function not refused");

  no_reply_a: assert property ( // see RULE_20
    (state == S_IDLE && RX_END && !accept) |=> (state == S_IDLE && !TX_VALID) [*2])
    else $error("answered a foreign or corrupt query");

endmodule
`default_nettype wire

// [dv/mbr_master_model.sv]
// Polling master model: sends query frames and drains response bytes.
// Assumes the responder's byte handshake and a frame-end pulse per query.
`timescale 1ns/10ps
`default_nettype none
module mbr_master_model (
  // Clock
  input wire logic clk,
  // Query side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  // Response side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic done = 1'b0;
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b1;
  end
  // Slow mode withholds ready for one cycle of every byte, so each byte must be held
  always @(posedge clk) tx_ready <= slow ? (tx_valid && !tx_ready) : 1'b1;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last) done <= 1'b1;
    end
  end
  // Bytes go out whole, in field order, then the frame end
  task automatic send(input logic [7:0] b[$]);
    got.delete();
    done = 1'b0;
    foreach (b[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= b[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    // Idle data is scrambled so a stale byte is never reused
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/tb_mbr_responder.sv]
// Self-checking bench for the read-query responder.
// Assumes the master model drives the query link and drains responses.
`timescale 1ns/10ps
`default_nettype none
module tb_mbr_responder;
  import mbr_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, text_mode = 1'b0, relay_state = 1'b0, loop_a = 1'b0;
  logic [7:0] slave_addr = 8'h01;
  logic [18:0] alarm = 19'h00000;
  logic [31:0] temp = 32'h00000000;
  logic [5:0] rmap = 6'h00;
  logic rx_valid, rx_end, tx_ready, tx_valid, tx_last;
  logic [7:0] rx_data, tx_data;
  int bad_count = 0, check_count = 0;
  initial forever #20 clk = ~clk;
  mbr_responder mbr_responder_inst (.CLK_SYS(clk), .RESETN(resetn), .SLAVE_ADDR(slave_addr),
    .TEXT_MODE(text_mode), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_END(rx_end),
    .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .ALARM_STATUS(alarm), .RELAY_STATE(relay_state), .LOOP_A_FAULT(loop_a),
    .TEMPERATURE(temp), .RELAY_MAP(rmap));
  mbr_master_model mbr_master_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Appends CRC low then high in binary mode, or the LRC byte in text mode
  function automatic void add_check(ref logic [7:0] b[$], input logic txt);
    logic [15:0] c;
    logic [7:0] s;
    c = 16'hFFFF;
    s = 8'h00;
    foreach (b[i]) begin
      s = s + b[i];
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    if (txt) b.push_back(8'h00 - s);
    else b = {b, c[7:0], c[15:8]};
  endfunction
  // Sends one query and compares the whole answer; an empty expectation means silence
  task automatic run(input mbr_query_t q, input logic [7:0] exp[$], input logic bad);
    logic [7:0] f[$];
    logic quiet;
    f = {q.addr, q.func, q.start[15:8], q.start[7:0], q.qty[15:8], q.qty[7:0]};
    quiet = (exp.size() == 0);
    add_check(f, text_mode);
    if (bad) f[f.size()-1] = ~f[f.size()-1];
    if (!quiet) add_check(exp, text_mode);
    mbr_master_model_inst.send(f);
    for (int i = 0; i < 300 && !mbr_master_model_inst.done; i++) @(posedge clk);
    check_count++;
    if (!quiet && !mbr_master_model_inst.done) begin
      bad_count++;
      $display("FAIL %0t: final byte never marked last", $time);
    end
    if (mbr_master_model_inst.got.size() != exp.size()) begin
      bad_count++;
      $display("FAIL %0t: response length %0d", $time, mbr_master_model_inst.got.size());
    end
    foreach (exp[i]) begin
      if (i < mbr_master_model_inst.got.size()) begin
        chk(mbr_master_model_inst.got[i], exp[i]);
      end
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic t_relay_bit;
    @(posedge clk);
    slave_addr <= 8'h05;
    relay_state <= 1'b1;
    run({8'h05, FUNC_DISC, 16'h0012, 16'h0001}, '{8'h05, 8'h02, 8'h01, 8'h01}, 0);
    $display("done relay_bit");
  endtask
  task automatic t_all_inputs;
    @(posedge clk);
    slave_addr <= 8'h12;
    relay_state <= 1'b0;
    loop_a <= 1'b1;
    alarm <= 19'h40005;
    run({8'h12, FUNC_DISC, 16'h0000, 16'h0015},
      '{8'h12, 8'h02, 8'h03, 8'h05, 8'h00, 8'h18}, 0);
    $display("done all_inputs");
  endtask
  task automatic t_temperature;
    @(posedge clk);
    slave_addr <= 8'h0A;
    temp <= 32'h4290999A;
    mbr_master_model_inst.slow = 1'b1;
    run({8'h0A, FUNC_INPUT, 16'h0008, 16'h0002},
      '{8'h0A, 8'h04, 8'h04, 8'h42, 8'h90, 8'h99, 8'h9A}, 0);
    // Misaligned start is answered word by word, unmapped word reads zero
    run({8'h0A, FUNC_INPUT, 16'h0009, 16'h0002},
      '{8'h0A, 8'h04, 8'h04, 8'h99, 8'h9A, 8'h00, 8'h00}, 0);
    mbr_master_model_inst.slow = 1'b0;
    $display("done temperature");
  endtask
  task automatic t_relay_map;
    @(posedge clk);
    slave_addr <= 8'h20;
    rmap <= 6'h16;
    run({8'h20, FUNC_HOLD, 16'h0073, 16'h0001},
      '{8'h20, 8'h03, 8'h02, 8'h00, 8'h16}, 0);
    $display("done relay_map");
  endtask
  task automatic t_exception;
    @(posedge clk);
    slave_addr <= 8'h00;
    // Out-of-range setting answers at the default address; unmapped word reads zero
    run({8'h01, FUNC_INPUT, 16'h0000, 16'h0001},
      '{8'h01, 8'h04, 8'h02, 8'h00, 8'h00}, 0);
    slave_addr <= 8'hF7;
    run({8'hF7, 8'h05, 16'h0000, 16'h0001}, '{8'hF7, 8'h85, EXC_FUNC}, 0);
    run({8'hF7, FUNC_DISC, 16'h0014, 16'h0002}, '{8'hF7, 8'h82, EXC_ADDR}, 0);
    run({8'hF7, FUNC_HOLD, 16'h0073, 16'h0000}, '{8'hF7, 8'h83, EXC_VALUE}, 0);
    $display("done exception");
  endtask
  task automatic t_ignore;
    run({8'hF6, FUNC_DISC, 16'h0000, 16'h0001}, '{}, 0);
    run({8'hF7, FUNC_DISC, 16'h0000, 16'h0001}, '{}, 1);
    $display("done ignore");
  endtask
  task automatic t_text;
    @(posedge clk);
    slave_addr <= 8'h05;
    text_mode <= 1'b1;
    relay_state <= 1'b1;
    @(posedge clk);
    run({8'h05, FUNC_DISC, 16'h0012, 16'h0001}, '{8'h05, 8'h02, 8'h01, 8'h01}, 0);
    text_mode <= 1'b0;
    $display("done text");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_relay_bit();
    t_all_inputs();
    t_temperature();
    t_relay_map();
    t_exception();
    t_ignore();
    t_text();
    wrap_up();
  end
  // The twelve queries together need well under 4000 cycles
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
